// >>> shared/rmwseq_pkg.sv
/*
  Shared constants and types of the read-modify-write bus cycle sequencer.
  Assumes one clk_sys cycle stands for one half-clock bus state.
*/
`default_nettype none
package rmwseq_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BEAT_W = 3;
  localparam int unsigned TYPE_LSB = 16;
  localparam int unsigned TYPE_MSB = 19;
  localparam logic [2:0] FC_CPU_SPACE = 3'h7;
  localparam logic [3:0] CPU_TYPE_BKPT = 4'h0;
  localparam logic [3:0] CPU_TYPE_MODULE = 4'h1;
  localparam logic [3:0] CPU_TYPE_COPRO = 4'h2;
  localparam logic [3:0] CPU_TYPE_IACK = 4'hf;
  localparam logic STB_NEGATED = 1'b1;
  localparam logic RNW_READ = 1'b1;
  localparam logic RNW_WRITE = 1'b0;
  localparam logic [2:0] FC_RST = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [BEAT_W-1:0] BEAT_RST = 3'h0;

  // Gray codes along the read, modify and write path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_S0 = 4'h1,
    ST_S1 = 4'h3,
    ST_S2 = 4'h2,
    ST_S3 = 4'h6,
    ST_S4 = 4'h7,
    ST_S5 = 4'h5,
    ST_MOD = 4'h4,
    ST_S6 = 4'hc,
    ST_S7 = 4'hd,
    ST_S8 = 4'hf,
    ST_S9 = 4'he,
    ST_S10 = 4'ha,
    ST_S11 = 4'hb
  } rmwseq_state_t;
endpackage
`default_nettype wire

// >>> shared/rmwseq_mem_if.sv
/*
  Port between the sequencer and its operand read register store.
  Assumes both ends run on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
interface rmwseq_mem_if #(parameter int unsigned AW = 3, parameter int unsigned DW = 32);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// >>> rtl/rmwseq_opnd_mem.sv
/*
  Small store for the operand beats captured during the read portion.
  Assumes writes and reads are qualified by the shared clock enable.
*/
`timescale 1ns/1ps
`default_nettype none
module rmwseq_opnd_mem #(
  parameter int unsigned AW = 3,
  parameter int unsigned DW = 32
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  rmwseq_mem_if.mem port
);
  localparam int unsigned DEPTH = 1 << AW;
  logic [DW-1:0] mem_ff [DEPTH];
  logic [DW-1:0] rd_data_ff;

  always_ff @(posedge clk_sys)
  begin
    if (ce && port.wr_en)
    begin
      mem_ff[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rd_data_ff <= '0;
    end
    else if (ce)
    begin
      rd_data_ff <= mem_ff[port.rd_addr];
    end
  end

  assign port.rd_data = rd_data_ff;
endmodule // rmwseq_opnd_mem
`default_nettype wire

// >>> rtl/rmwseq_beat_cnt.sv
/*
  Beat index counter with a last-beat flag.
  Assumes limit holds the beat count minus one while counting.
*/
`timescale 1ns/1ps
`default_nettype none
module rmwseq_beat_cnt #(
  parameter int unsigned W = 3
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic step,
  input wire logic [W-1:0] limit,
  output logic [W-1:0] idx,
  output logic last
);
  logic [W-1:0] idx_ff;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      idx_ff <= '0;
    end
    else if (ce)
    begin
      if (clear)
      begin
        idx_ff <= '0;
      end
      else if (step)
      begin
        idx_ff <= W'(idx_ff + 1'b1);
      end
    end
  end

  assign idx = idx_ff;
  assign last = (idx_ff == limit);
endmodule // rmwseq_beat_cnt
`default_nettype wire

// >>> rtl/rmwseq_top.sv
/*
  Read-modify-write bus cycle sequencer: read beats S0-S5, idle modify states,
  optional write beats S6-S11 with acknowledge wait states, locked sequence flag.
  Assumes synchronous inputs, active-low acknowledges and one state per clk_sys cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module rmwseq_top #(
  parameter int unsigned AW = rmwseq_pkg::ADDR_W,
  parameter int unsigned DW = rmwseq_pkg::DATA_W,
  parameter int unsigned BW = rmwseq_pkg::BEAT_W,
  parameter bit FULL_ADDR = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic rmw_start,
  input wire logic [BW-1:0] rd_beats_m1,
  input wire logic [BW-1:0] wr_beats_m1,
  input wire logic cpu_space,
  input wire logic [3:0] cpu_type,
  input wire logic [2:0] fc_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wr_data_in,
  input wire logic write_go,
  input wire logic write_skip,
  input wire logic [DW-1:0] data_in,
  input wire logic [1:0] port_size_ack_n,
  input wire logic bus_request_n,
  input wire logic [BW-1:0] rd_sel,
  output logic [AW-1:0] address,
  output logic [DW-1:0] data_out,
  output logic data_oe,
  output logic read_not_write,
  output logic [2:0] function_code,
  output logic address_strobe_n,
  output logic data_strobe_n,
  output logic buffer_enable_n,
  output logic early_cycle_start_n,
  output logic operand_cycle_start_n,
  output logic locked_cycle_flag_n,
  output logic bus_grant_n,
  output logic [BW-1:0] beat_idx,
  output logic in_write,
  output logic modify_phase,
  output logic seq_done,
  output logic [DW-1:0] read_data
);
  import rmwseq_pkg::*;

  rmwseq_state_t state_ff, nxt_state;
  logic ack_ff, rd_last, wr_last, wr_clear;
  logic [BW-1:0] rd_idx, wr_idx, rd_lim_ff, wr_lim_ff, beat_idx_ff;
  logic [AW-1:0] address_ff;
  logic [DW-1:0] data_out_ff;
  logic [2:0] fc_ff;
  logic data_oe_ff, rnw_ff, as_n_ff, ds_n_ff, buffer_enable_n_n_ff, cs_n_ff, lock_n_ff, grant_n_ff;
  logic in_write_ff, modify_ff, done_ff;

  rmwseq_mem_if #(.AW(BW), .DW(DW)) mem_if ();

  function automatic logic f_as(input rmwseq_state_t s);
    return s inside {ST_S1, ST_S2, ST_S3, ST_S4, ST_S7, ST_S8, ST_S9, ST_S10};
  endfunction

  function automatic logic f_ds(input rmwseq_state_t s);
    return s inside {ST_S1, ST_S2, ST_S3, ST_S4, ST_S9, ST_S10};
  endfunction

  function automatic logic f_buffer_enable_n(input rmwseq_state_t s);
    return s inside {ST_S2, ST_S3, ST_S4, ST_S7, ST_S8, ST_S9, ST_S10, ST_S11};
  endfunction

  function automatic logic f_drive(input rmwseq_state_t s);
    return s inside {ST_S8, ST_S9, ST_S10, ST_S11};
  endfunction

  // Places the CPU space type code on address bits 19-16
  function automatic logic [AW-1:0] f_addr(input logic [AW-1:0] a, input logic cs, input logic [3:0] t);
    logic [AW-1:0] r;
    r = a;
    if (cs)
    begin
      r[TYPE_MSB:TYPE_LSB] = t;
    end
    return r;
  endfunction

  rmwseq_beat_cnt #(.W(BW)) u_rd_cnt (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .clear(state_ff == ST_IDLE),
    .step(state_ff == ST_S5 && !rd_last),
    .limit(rd_lim_ff), .idx(rd_idx), .last(rd_last)
  );

  assign wr_clear = (state_ff == ST_MOD);

  rmwseq_beat_cnt #(.W(BW)) u_wr_cnt (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .clear(wr_clear),
    .step(state_ff == ST_S11 && !wr_last),
    .limit(wr_lim_ff), .idx(wr_idx), .last(wr_last)
  );

  // Read data taken at the end of S4
  assign mem_if.wr_en = (state_ff == ST_S4);
  assign mem_if.wr_addr = rd_idx;
  assign mem_if.wr_data = data_in;
  assign mem_if.rd_addr = rd_sel;

  rmwseq_opnd_mem #(.AW(BW), .DW(DW)) u_mem (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .port(mem_if.mem)
  );

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (rmw_start) nxt_state = ST_S0;
      ST_S0: nxt_state = ST_S1;
      ST_S1: nxt_state = ST_S2;
      ST_S2: nxt_state = ST_S3;
      ST_S3: if (ack_ff) nxt_state = ST_S4;
      ST_S4: nxt_state = ST_S5;
      ST_S5: nxt_state = rd_last ? ST_MOD : ST_S0;
      ST_MOD:
      begin
        if (write_go) nxt_state = ST_S6;
        else if (write_skip) nxt_state = ST_IDLE;
      end
      ST_S6: nxt_state = ST_S7;
      ST_S7: nxt_state = ST_S8;
      ST_S8: nxt_state = ST_S9;
      ST_S9: if (ack_ff) nxt_state = ST_S10;
      ST_S10: nxt_state = ST_S11;
      ST_S11: nxt_state = wr_last ? ST_IDLE : ST_S6;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n) state_ff <= ST_IDLE;
    else if (ce) state_ff <= nxt_state;
  end

  // Acknowledge sampled at the end of S2/S8 and on every wait state
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n) ack_ff <= 1'b0;
    else if (ce) ack_ff <= (state_ff inside {ST_S2, ST_S3, ST_S8, ST_S9}) && !(&port_size_ack_n);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rd_lim_ff <= BEAT_RST;
      wr_lim_ff <= BEAT_RST;
    end
    else if (ce)
    begin
      if (state_ff == ST_IDLE && rmw_start) rd_lim_ff <= rd_beats_m1;
      if (state_ff == ST_MOD && write_go) wr_lim_ff <= wr_beats_m1;
    end
  end

  // Address, direction and function code change only on entering S0 or S6
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      address_ff <= ADDR_RST;
      rnw_ff <= RNW_READ;
      fc_ff <= FC_RST;
    end
    else if (ce)
    begin
      if (nxt_state == ST_S0 || nxt_state == ST_S6)
      begin
        address_ff <= f_addr(addr_in, cpu_space, cpu_type);
        fc_ff <= cpu_space ? FC_CPU_SPACE : fc_in;
        rnw_ff <= (nxt_state == ST_S0) ? RNW_READ : RNW_WRITE;
      end
    end
  end

  // Write data loaded on entering S8 and held through S11
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      data_out_ff <= DATA_RST;
      data_oe_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (nxt_state == ST_S8) data_out_ff <= wr_data_in;
      data_oe_ff <= f_drive(nxt_state);
    end
  end

  // Strobes decoded from the coming state
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      as_n_ff <= STB_NEGATED;
      ds_n_ff <= STB_NEGATED;
      buffer_enable_n_n_ff <= STB_NEGATED;
      cs_n_ff <= STB_NEGATED;
    end
    else if (ce)
    begin
      as_n_ff <= !f_as(nxt_state);
      ds_n_ff <= !f_ds(nxt_state);
      buffer_enable_n_n_ff <= !(FULL_ADDR && f_buffer_enable_n(nxt_state));
      cs_n_ff <= !(FULL_ADDR && (nxt_state == ST_S0 || nxt_state == ST_S6));
    end
  end

  // Lock spans the whole sequence; grant only while nothing is locked
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      lock_n_ff <= STB_NEGATED;
      grant_n_ff <= STB_NEGATED;
    end
    else if (ce)
    begin
      lock_n_ff <= (nxt_state == ST_IDLE);
      grant_n_ff <= !(!bus_request_n && state_ff == ST_IDLE && nxt_state == ST_IDLE);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      beat_idx_ff <= BEAT_RST;
      in_write_ff <= 1'b0;
      modify_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else if (ce)
    begin
      beat_idx_ff <= (state_ff inside {ST_MOD, ST_S6, ST_S7, ST_S8, ST_S9, ST_S10, ST_S11}) ? wr_idx : rd_idx;
      in_write_ff <= f_drive(nxt_state) || nxt_state inside {ST_S6, ST_S7};
      modify_ff <= (nxt_state == ST_MOD);
      done_ff <= (state_ff != ST_IDLE) && (nxt_state == ST_IDLE);
    end
  end

  assign address = address_ff;
  assign data_out = data_out_ff;
  assign data_oe = data_oe_ff;
  assign read_not_write = rnw_ff;
  assign function_code = fc_ff;
  assign address_strobe_n = as_n_ff;
  assign data_strobe_n = ds_n_ff;
  assign buffer_enable_n = buffer_enable_n_n_ff;
  assign early_cycle_start_n = cs_n_ff;
  assign operand_cycle_start_n = cs_n_ff;
  assign locked_cycle_flag_n = lock_n_ff;
  assign bus_grant_n = grant_n_ff;
  assign beat_idx = beat_idx_ff;
  assign in_write = in_write_ff;
  assign modify_phase = modify_ff;
  assign seq_done = done_ff;
  assign read_data = mem_if.rd_data;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_wr_wait;
    state_ff == ST_S9 && !ack_ff && ce;
  endsequence

  sequence s_rd_wait;
    state_ff == ST_S3 && !ack_ff && ce;
  endsequence

  sequence s_s6_s7;
    state_ff == ST_S6 && ce ##1 state_ff == ST_S7 && ce;
  endsequence

  read_capture_a: assert property (mem_if.wr_en |-> state_ff == ST_S4)
    else $error("read capture outside S4");
  s5_release_a: assert property (state_ff == ST_S5 |-> as_n_ff && ds_n_ff && buffer_enable_n_n_ff)
    else $error("strobes still asserted in S5");
  read_hold_a: assert property (state_ff inside {ST_S1, ST_S2, ST_S3, ST_S4, ST_S5, ST_MOD} |-> rnw_ff)
    else $error("direction not read before S6");
  addr_stable_a: assert property (!(state_ff inside {ST_IDLE, ST_S0, ST_S6}) |-> $stable(address_ff))
    else $error("address moved outside S0 or S6");
  modify_quiet_a: assert property (state_ff == ST_MOD |-> as_n_ff && ds_n_ff && !data_oe_ff && cs_n_ff)
    else $error("control asserted in idle states");
  skip_write_a: assert property (state_ff == ST_MOD && ce && !write_go && write_skip
    |=> state_ff == ST_IDLE && lock_n_ff)
    else $error("write portion not skipped");
  no_early_drive_a: assert property (data_oe_ff |-> state_ff inside {ST_S8, ST_S9, ST_S10, ST_S11})
    else $error("data bus driven before S8");
  start_pulse_a: assert property (!cs_n_ff |-> state_ff inside {ST_S0, ST_S6})
    else $error("cycle start outside S0 or S6");
  write_start_a: assert property (s_s6_s7 |=> state_ff == ST_S8 && !as_n_ff && !rnw_ff && data_oe_ff)
    else $error("S6 to S8 sequence wrong");
  wr_wait_a: assert property (s_wr_wait |=> state_ff == ST_S9 && !ds_n_ff)
    else $error("write wait state not held");
  rd_wait_a: assert property (s_rd_wait |=> state_ff == ST_S3)
    else $error("read wait state not held");
  ack_advance_a: assert property (state_ff == ST_S9 && ack_ff && ce |=> state_ff == ST_S10)
    else $error("write did not end after ack");
  s10_steady_a: assert property (state_ff == ST_S10 && $past(state_ff) == ST_S9
    |-> $stable(as_n_ff) && $stable(ds_n_ff) && $stable(data_oe_ff))
    else $error("controls changed in S10");
  s11_hold_a: assert property (state_ff == ST_S11 |-> as_n_ff && ds_n_ff && data_oe_ff && !rnw_ff)
    else $error("S11 strobe or hold wrong");
  lock_span_a: assert property (state_ff != ST_IDLE |-> !lock_n_ff)
    else $error("lock dropped mid sequence");
  no_grant_a: assert property (!lock_n_ff |-> grant_n_ff)
    else $error("bus granted while locked");
endmodule // rmwseq_top
`default_nettype wire

// >>> bench/rmwseq_resp_model.sv
/*
  Responder model for the sequencer's far side: acknowledges a strobed cycle lat+1 cycles after the address strobe falls.
  Assumes clk_sys and active-low strobes from the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module rmwseq_resp_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic read_not_write,
  input wire logic locked_cycle_flag_n,
  input wire logic [31:0] data_out,
  input wire logic [3:0] lat,
  input wire logic [31:0] base,
  output logic [1:0] port_size_ack_n,
  output logic [31:0] data_in,
  output logic [31:0] wr_seen
);
  logic [3:0] cnt_ff;
  logic ack_ff;
  logic [2:0] beat_ff;
  logic [31:0] last_ff;
  logic drive;
  assign drive = ack_ff && read_not_write;
  assign port_size_ack_n = ack_ff ? 2'h2 : 2'h3;
  assign data_in = drive ? base + 32'(beat_ff) : ~last_ff;
  always @(posedge clk_sys)
  begin
    if (!rst_n || address_strobe_n)
    begin
      cnt_ff <= 4'h0;
      ack_ff <= 1'b0;
    end
    else if (cnt_ff == lat)
      ack_ff <= 1'b1;
    else
      cnt_ff <= cnt_ff + 4'h1;
  end
  always @(posedge clk_sys)
  begin
    if (drive)
      last_ff <= data_in;
    if (locked_cycle_flag_n)
      beat_ff <= 3'h0;
    else if (ack_ff && address_strobe_n && read_not_write)
      beat_ff <= beat_ff + 3'h1;
    if (ack_ff && !data_strobe_n && !read_not_write)
      wr_seen <= data_out;
  end
endmodule // rmwseq_resp_model
`default_nettype wire

// >>> bench/test_rmw_bus_cycle_sequencer.sv
/*
  Self-checking bench of the sequencer with a responder model.
  Assumes one clk_sys cycle per bus state and inputs driven at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module test_rmw_bus_cycle_sequencer;
  import rmwseq_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n, ce, rmw_start, cpu_space, write_go, write_skip, bus_request_n;
  logic [2:0] rd_beats_m1, wr_beats_m1, fc_in, rd_sel, function_code, beat_idx;
  logic [3:0] cpu_type, lat;
  logic [31:0] addr_in, wr_data_in, data_in, base, wr_seen, address, data_out, read_data, mod_addr;
  logic [1:0] port_size_ack_n;
  logic data_oe, read_not_write, address_strobe_n, data_strobe_n, buffer_enable_n, early_cycle_start_n;
  logic operand_cycle_start_n, locked_cycle_flag_n, bus_grant_n, in_write, modify_phase, seq_done;
  logic [2:0] mod_fc, rd_beat, wr_beat;
  logic [6:0] trace [$];
  int fail_count = 0;
  int tests_run = 0;
  int as_low, starts, grant_bad, ocs_low, wr_cycles;

  always #2.5 clk_sys = ~clk_sys;

  rmwseq_top u_dut (.clk_sys, .rst_n, .ce, .rmw_start, .rd_beats_m1, .wr_beats_m1, .cpu_space,
    .cpu_type, .fc_in, .addr_in, .wr_data_in, .write_go, .write_skip, .data_in, .port_size_ack_n,
    .bus_request_n, .rd_sel, .address, .data_out, .data_oe, .read_not_write, .function_code,
    .address_strobe_n, .data_strobe_n, .buffer_enable_n, .early_cycle_start_n, .operand_cycle_start_n,
    .locked_cycle_flag_n, .bus_grant_n, .beat_idx, .in_write, .modify_phase, .seq_done, .read_data);

  rmwseq_resp_model u_resp (.clk_sys, .rst_n, .address_strobe_n, .data_strobe_n, .read_not_write,
    .locked_cycle_flag_n, .data_out, .lat, .base, .port_size_ack_n, .data_in, .wr_seen);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Runs one sequence, tracing the bus controls once per state
  task automatic run_seq(input logic [2:0] rm1, input logic [2:0] wm1, input logic go, input logic req);
    int n;
    @(negedge clk_sys);
    rd_beats_m1 = rm1;
    wr_beats_m1 = wm1;
    write_go = go;
    write_skip = 1'b1;
    bus_request_n = req;
    trace.delete();
    as_low = 0;
    starts = 0;
    grant_bad = 0;
    ocs_low = 0;
    wr_cycles = 0;
    rmw_start = 1'b1;
    for (n = 0; n < 300; n++)
    begin
      @(negedge clk_sys);
      rmw_start = 1'b0;
      trace.push_back({address_strobe_n, data_strobe_n, buffer_enable_n, read_not_write,
        locked_cycle_flag_n, data_oe, early_cycle_start_n});
      if (!address_strobe_n)
        as_low++;
      if (!early_cycle_start_n)
        starts++;
      if (!bus_grant_n && !locked_cycle_flag_n)
        grant_bad++;
      if (!operand_cycle_start_n)
        ocs_low++;
      if (in_write)
        wr_cycles++;
      if (!data_strobe_n)
      begin
        if (read_not_write)
          rd_beat = beat_idx;
        else
          wr_beat = beat_idx;
      end
      if (modify_phase)
      begin
        mod_addr = address;
        mod_fc = function_code;
      end
      if (seq_done)
        break;
    end
    if (n == 300)
    begin
      fail_count++;
      wrap_up();
    end
  endtask

  task automatic show_beat(input logic [2:0] idx, input logic [31:0] exp);
    rd_sel = idx;
    repeat (2) @(negedge clk_sys);
    check(read_data, exp);
  endtask

  // One read, one write, prompt acknowledge: state by state
  task automatic walk_rw;
    logic [6:0] exp [14] = '{7'h78, 7'h19, 7'h09, 7'h09, 7'h09, 7'h79, 7'h79,
      7'h70, 7'h21, 7'h23, 7'h03, 7'h03, 7'h63, 7'h75};
    lat = 4'h0;
    run_seq(3'h0, 3'h0, 1'b1, 1'b1);
    check(32'(trace.size()), 32'd14);
    foreach (exp[i]) check(32'(trace[i]), 32'(exp[i]));
    check(mod_addr, addr_in);
    check(32'(mod_fc), 32'(fc_in));
    check(wr_seen, wr_data_in);
    check(32'(wr_cycles), 32'd6);
    check(32'(ocs_low), 32'd2);
    show_beat(3'h0, base);
  endtask

  // Two reads, two writes, slow acknowledge
  task automatic multi_wait;
    lat = 4'h2;
    run_seq(3'h1, 3'h1, 1'b1, 1'b1);
    check(32'(as_low), 32'd24);
    check(32'(starts), 32'd4);
    check(32'(ocs_low), 32'd4);
    check(32'(wr_cycles), 32'd16);
    check(32'(rd_beat), 32'd1);
    check(32'(wr_beat), 32'd1);
    check(wr_seen, wr_data_in);
    show_beat(3'h1, base + 32'h1);
  endtask

  // No write after the modify states
  task automatic skip_write;
    lat = 4'h1;
    run_seq(3'h0, 3'h0, 1'b0, 1'b1);
    check(32'(trace.size()), 32'd9);
    check(32'(as_low), 32'd5);
    check(32'(trace[7]), 32'h79);
    check(32'(trace[8]), 32'h7d);
  endtask

  // Every CPU space type
  task automatic cpu_types;
    logic [3:0] kinds [4] = '{CPU_TYPE_IACK, CPU_TYPE_COPRO, CPU_TYPE_BKPT, CPU_TYPE_MODULE};
    cpu_space = 1'b1;
    foreach (kinds[i])
    begin
      cpu_type = kinds[i];
      run_seq(3'h0, 3'h0, 1'b0, 1'b1);
      check(32'(mod_fc), 32'(FC_CPU_SPACE));
      check(32'(mod_addr[19:16]), 32'(kinds[i]));
    end
    cpu_space = 1'b0;
  endtask

  // Clock enable low freezes a sequence in S1
  task automatic ce_hold;
    int n;
    lat = 4'h0;
    @(negedge clk_sys);
    rd_beats_m1 = 3'h0;
    write_go = 1'b0;
    write_skip = 1'b1;
    rmw_start = 1'b1;
    repeat (2) @(negedge clk_sys);
    rmw_start = 1'b0;
    ce = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(32'({address_strobe_n, data_strobe_n, buffer_enable_n, read_not_write, locked_cycle_flag_n,
      data_oe, early_cycle_start_n}), 32'h19);
    check(address, addr_in);
    ce = 1'b1;
    for (n = 0; n < 20 && seq_done !== 1'b1; n++)
      @(negedge clk_sys);
    check(32'(seq_done), 32'd1);
  endtask

  // Bus request held through a locked sequence
  task automatic grant_block;
    int n;
    lat = 4'h0;
    run_seq(3'h0, 3'h0, 1'b1, 1'b0);
    check(32'(grant_bad), 32'd0);
    for (n = 0; n < 4 && bus_grant_n !== 1'b0; n++)
      @(negedge clk_sys);
    check(32'(bus_grant_n), 32'd0);
    bus_request_n = 1'b1;
    repeat (3) @(negedge clk_sys);
  endtask

  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    rmw_start = 1'b0;
    cpu_space = 1'b0;
    write_go = 1'b0;
    write_skip = 1'b0;
    bus_request_n = 1'b1;
    rd_beats_m1 = 3'h0;
    wr_beats_m1 = 3'h0;
    fc_in = 3'h5;
    rd_sel = 3'h0;
    cpu_type = 4'h0;
    lat = 4'h0;
    addr_in = 32'h0001_2344;
    wr_data_in = 32'hc3a5_5a3c;
    base = 32'h1234_0000;
    repeat (16) @(negedge clk_sys);
    check(32'({address_strobe_n, data_strobe_n, buffer_enable_n, read_not_write, locked_cycle_flag_n,
      data_oe, early_cycle_start_n}), 32'h7d);
    rst_n = 1'b1;
    walk_rw();
    multi_wait();
    skip_write();
    cpu_types();
    ce_hold();
    grant_block();
    wrap_up();
  end
endmodule // test_rmw_bus_cycle_sequencer
`default_nettype wire
